//--- include/dma_pkg.sv
// Shared constants and types for the two-channel peripheral transfer controller
package dma_pkg;

  // Channel and request source counts, select, config and APB address widths
  localparam int CH_NUM = 2;
  localparam int SRC_NUM = 10;
  localparam int SEL_W = 4;
  localparam int CFG_W = 8;
  localparam int APB_AW = 8;

  // Register indices inside a channel, then the config index and index bits; byte address is four times the index
  localparam logic [3:0] REG_ODR = 4'h0;
  localparam logic [3:0] REG_CCR = 4'h1;
  localparam logic [3:0] REG_CER = 4'h2;
  localparam logic [3:0] REG_CSR = 4'h3;
  localparam logic [3:0] REG_SAR = 4'h4;
  localparam logic [3:0] REG_DAR = 4'h8;
  localparam logic [3:0] REG_BCR = 4'hC;
  localparam logic [5:0] IDX_CFG = 6'h20;
  localparam int IDX_CH_BIT = 4;
  localparam int IDX_HI_BIT = 5;

  // Operation definition fields
  localparam int ODR_SAC = 31;
  localparam int ODR_DAC = 30;
  localparam int ODR_PERIPHERAL_REGISTER_SIZE = 28;
  localparam int ODR_TRANSFER_WIDTH = 26;
  localparam int ODR_MEMORY_WIDTH = 25;
  localparam int ODR_BST = 24;
  localparam logic [31:0] ODR_MASK = 32'hFF00_0000;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_BAD = 2'h3;

  // Channel control fields
  localparam int CCR_RST = 23;
  localparam int CCR_ABT = 22;
  localparam int CCR_CEN = 20;
  localparam int CCR_RPL = 19;
  localparam int CCR_ENDEN = 16;

  // Status and error fields
  localparam int CSR_OPC = 0;
  localparam int CSR_ERR = 1;
  localparam int CER_CFG = 0;
  localparam int CER_BUS = 1;
  localparam int CER_ALIGN = 2;
  localparam int CER_W = 3;

  // Transfer step and external source code
  localparam logic [31:0] STEP_BYTES = 32'h0000_0004;
  localparam logic [3:0] SRC_EXT = 4'hA;

  typedef enum logic [2:0] {
    CH_IDLE = 3'b000,
    CH_WAIT = 3'b001,
    CH_READ = 3'b010,
    CH_WRITE = 3'b011,
    CH_ACK = 3'b100
  } chan_state_t;

  typedef struct packed {
    chan_state_t st;
    logic [31:0] operation_definition_register;
    logic channel_enable;
    logic request_polarity;
    logic end_enable;
    logic operation_complete_flag;
    logic err;
    logic [CER_W-1:0] channel_error_register;
    logic [31:0] source_pointer_register;
    logic [31:0] destination_pointer_register;
    logic [31:0] transfer_length_register;
    logic [31:0] data;
    logic ext_act;
  } chan_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sb_req_t;

endpackage : dma_pkg

//--- rtl/req_detect.sv
// Request detector: polarity, edge or level sampling of one channel request
`timescale 1ns/1ps
module req_detect import dma_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request path
  input wire logic req_raw,
  input wire logic level_mode,
  input wire logic active_high,
  input wire logic armed,
  input wire logic taken,
  output logic req_seen
);

  typedef struct packed {
    logic prev;
    logic pend;
  } det_t;

  det_t r;
  det_t next_r;
  logic asserted;

  // Pending edge; a new edge in the clearing cycle is kept
  always_comb begin
    asserted = (req_raw == active_high);
    next_r.prev = asserted;
    next_r.pend = r.pend;
    if (taken || !armed) begin
      next_r.pend = 1'b0;
    end
    if (armed && asserted && !r.prev) begin
      next_r.pend = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Level mode follows the pin, edge mode the pending flag
  assign req_seen = level_mode ? (armed && asserted) : r.pend;

endmodule : req_detect

//--- rtl/transfer_controller.sv
// Two-channel peripheral transfer controller with APB registers and system bus master
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
module transfer_controller import dma_pkg::*; (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // APB register slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // System bus master
  output sb_req_t SB_OUT,
  input wire logic SB_ACK,
  input wire logic SB_ERR,
  input wire logic [31:0] SB_RDATA,
  // On-chip peripheral requests and acknowledges, indexed by source code
  input wire logic [SRC_NUM-1:0] PERIPH_REQ,
  output logic [SRC_NUM-1:0] PERIPH_ACK,
  // External request pin pair
  input wire logic EXT_REQ,
  output logic EXT_ACK_N,
  // Per-channel interrupts
  output logic [CH_NUM-1:0] CH_INT
);

  typedef struct packed {
    chan_t [CH_NUM-1:0] ch;
    logic [CFG_W-1:0] cfg;
    logic busy;
    logic owner;
    sb_req_t bus;
    logic [1:0] ext_sync;
    logic [31:0] prdata;
    logic [SRC_NUM-1:0] ack;
    logic ext_ack_n;
  } ctl_t;

  ctl_t s;
  ctl_t n;
  logic setup;
  logic access;
  logic mapped;
  logic wr;
  logic [5:0] idx;
  logic [3:0] sel_ch [CH_NUM];
  logic [CH_NUM-1:0] req_in;
  logic [CH_NUM-1:0] seen;
  logic [CH_NUM-1:0] taken;
  logic [CH_NUM-1:0] want;

  // Source-select field of one channel
  function automatic logic [SEL_W-1:0] sel_of(input logic [CFG_W-1:0] cfg, input int c);
    return cfg[c*SEL_W +: SEL_W];
  endfunction : sel_of

  // Request line chosen by a source code
  function automatic logic src_req(input logic [SEL_W-1:0] sel, input logic [SRC_NUM-1:0] per,
                                   input logic ext);
    if (sel < SEL_W'(SRC_NUM)) begin
      return per[sel];
    end
    return (sel == SRC_EXT) && ext;
  endfunction : src_req

  // Register index decode
  function automatic logic reg_mapped(input logic [5:0] i);
    if (i == IDX_CFG) begin
      return 1'b1;
    end
    if (i[IDX_HI_BIT]) begin
      return 1'b0;
    end
    case (i[3:0])
      REG_ODR, REG_CCR, REG_CER, REG_CSR, REG_SAR, REG_DAR, REG_BCR: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : reg_mapped

  // Settings checked when a channel is armed
  function automatic logic [CER_W-1:0] arm_check(input chan_t ch, input logic [SEL_W-1:0] sel);
    logic [CER_W-1:0] e;
    e = '0;
    e[CER_CFG] = (ch.operation_definition_register[ODR_SAC] == ch.operation_definition_register[ODR_DAC])
              || (ch.operation_definition_register[ODR_PERIPHERAL_REGISTER_SIZE +: 2] == SIZE_BAD)
              || (ch.operation_definition_register[ODR_TRANSFER_WIDTH +: 2] != SIZE_WORD)
              || ch.operation_definition_register[ODR_MEMORY_WIDTH]
              || (sel > SRC_EXT);
    e[CER_ALIGN] = (|ch.transfer_length_register[1:0]) || (ch.transfer_length_register == '0) || (|ch.source_pointer_register[1:0]) || (|ch.destination_pointer_register[1:0]);
    return e;
  endfunction : arm_check

  // APB phases; every access completes without wait states
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign idx = PADDR[7:2];
  assign mapped = reg_mapped(idx);
  assign wr = access && PWRITE && mapped;
  assign PREADY = access;
  assign PSLVERR = access && !mapped;
  assign PRDATA = s.prdata;

  // Request detection per channel
  for (genvar g = 0; g < CH_NUM; g++) begin : g_det
    assign sel_ch[g] = sel_of(s.cfg, g);
    assign req_in[g] = src_req(sel_ch[g], PERIPH_REQ, s.ext_sync[1]);
    assign taken[g] = (s.ch[g].st == CH_WAIT) && seen[g];
    req_detect u_det (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .req_raw(req_in[g]),
      .level_mode(s.ch[g].operation_definition_register[ODR_BST]),
      .active_high(s.ch[g].request_polarity),
      .armed(s.ch[g].channel_enable),
      .taken(taken[g]),
      .req_seen(seen[g])
    );
    // Status flags straight out, masking lives in the interrupt controller
    assign CH_INT[g] = s.ch[g].operation_complete_flag || s.ch[g].err;
  end

  // Next-state logic
  always_comb begin
    n = s;
    n.ack = '0;
    n.ext_sync = {s.ext_sync[0], EXT_REQ};
    // Read data captured in the setup phase, so PRDATA is a flop
    if (setup) begin
      n.prdata = '0;
      if (idx == IDX_CFG) begin
        n.prdata[CFG_W-1:0] = s.cfg;
      end else if (mapped) begin
        case (idx[3:0])
          REG_ODR: n.prdata = s.ch[idx[IDX_CH_BIT]].operation_definition_register;
          REG_CCR: begin
            n.prdata[CCR_CEN] = s.ch[idx[IDX_CH_BIT]].channel_enable;
            n.prdata[CCR_RPL] = s.ch[idx[IDX_CH_BIT]].request_polarity;
            n.prdata[CCR_ENDEN] = s.ch[idx[IDX_CH_BIT]].end_enable;
          end
          REG_CER: n.prdata[CER_W-1:0] = s.ch[idx[IDX_CH_BIT]].channel_error_register;
          REG_CSR: begin
            n.prdata[CSR_OPC] = s.ch[idx[IDX_CH_BIT]].operation_complete_flag;
            n.prdata[CSR_ERR] = s.ch[idx[IDX_CH_BIT]].err;
          end
          REG_SAR: n.prdata = s.ch[idx[IDX_CH_BIT]].source_pointer_register;
          REG_DAR: n.prdata = s.ch[idx[IDX_CH_BIT]].destination_pointer_register;
          REG_BCR: n.prdata = s.ch[idx[IDX_CH_BIT]].transfer_length_register;
          default: n.prdata = '0;
        endcase
      end
    end
    if (wr && idx == IDX_CFG) begin
      n.cfg = PWDATA[CFG_W-1:0];
    end
    for (int c = 0; c < CH_NUM; c++) begin
      // Plain register writes
      if (wr && !idx[IDX_HI_BIT] && idx[IDX_CH_BIT] == c[0]) begin
        case (idx[3:0])
          REG_ODR: n.ch[c].operation_definition_register = PWDATA & ODR_MASK;
          REG_SAR: n.ch[c].source_pointer_register = PWDATA;
          REG_DAR: n.ch[c].destination_pointer_register = PWDATA;
          REG_BCR: n.ch[c].transfer_length_register = PWDATA;
          REG_CSR: begin
            n.ch[c].operation_complete_flag = PWDATA[CSR_OPC];
            n.ch[c].err = PWDATA[CSR_ERR];
          end
          REG_CCR: begin
            n.ch[c].request_polarity = PWDATA[CCR_RPL];
            n.ch[c].end_enable = PWDATA[CCR_ENDEN];
            // Arming checks settings once, before any request is honoured
            if (PWDATA[CCR_CEN] && s.ch[c].st == CH_IDLE) begin
              n.ch[c].channel_error_register = arm_check(s.ch[c], sel_ch[c]);
              if (arm_check(s.ch[c], sel_ch[c]) != '0) begin
                n.ch[c].err = 1'b1;
                n.ch[c].channel_enable = 1'b0;
              end else begin
                n.ch[c].channel_enable = 1'b1;
                n.ch[c].st = CH_WAIT;
              end
            end
          end
          default: n.ch[c].channel_error_register = s.ch[c].channel_error_register;
        endcase
      end
      // Channel sequence; hardware sets come after writes so they win
      case (s.ch[c].st)
        CH_IDLE: n.ch[c].ext_act = 1'b0;
        CH_WAIT: begin
          if (seen[c]) begin
            n.ch[c].st = CH_READ;
            if (sel_ch[c] == SRC_EXT) begin
              n.ch[c].ext_act = 1'b1;
            end
          end
        end
        CH_READ, CH_WRITE: begin
          if (s.busy && s.owner == c[0] && SB_ACK) begin
            if (SB_ERR) begin
              n.ch[c].err = 1'b1;
              n.ch[c].channel_error_register[CER_BUS] = 1'b1;
              n.ch[c].channel_enable = 1'b0;
              n.ch[c].ext_act = 1'b0;
              n.ch[c].st = CH_IDLE;
            end else if (s.ch[c].st == CH_READ) begin
              n.ch[c].data = SB_RDATA;
              n.ch[c].st = CH_WRITE;
            end else begin
              if (sel_ch[c] < SEL_W'(SRC_NUM)) begin
                n.ack[sel_ch[c]] = 1'b1;
              end
              n.ch[c].st = CH_ACK;
            end
          end
        end
        CH_ACK: begin
          n.ch[c].transfer_length_register = s.ch[c].transfer_length_register - STEP_BYTES;
          if (s.ch[c].operation_definition_register[ODR_SAC]) begin
            n.ch[c].source_pointer_register = s.ch[c].source_pointer_register + STEP_BYTES;
          end
          if (s.ch[c].operation_definition_register[ODR_DAC]) begin
            n.ch[c].destination_pointer_register = s.ch[c].destination_pointer_register + STEP_BYTES;
          end
          if (s.ch[c].transfer_length_register == STEP_BYTES) begin
            n.ch[c].operation_complete_flag = 1'b1;
            n.ch[c].channel_enable = 1'b0;
            n.ch[c].ext_act = 1'b0;
            n.ch[c].st = CH_IDLE;
          end else begin
            n.ch[c].st = CH_WAIT;
          end
        end
        default: n.ch[c].st = CH_IDLE;
      endcase
      // Stop, abort and software reset override the sequence
      if (wr && !idx[IDX_HI_BIT] && idx[IDX_CH_BIT] == c[0] && idx[3:0] == REG_CCR) begin
        if (PWDATA[CCR_RST]) begin
          n.ch[c] = '0;
        end else if (PWDATA[CCR_ABT] || (!PWDATA[CCR_CEN] && s.ch[c].st != CH_IDLE)) begin
          n.ch[c].st = CH_IDLE;
          n.ch[c].channel_enable = 1'b0;
          n.ch[c].ext_act = 1'b0;
        end
      end
    end
    // Bus demand from the next channel states, kept inside this process to avoid a comb loop
    for (int c = 0; c < CH_NUM; c++) begin
      want[c] = (n.ch[c].st == CH_READ) || (n.ch[c].st == CH_WRITE);
    end
    // Bus ownership: a finished or abandoned cycle frees the bus
    if (s.busy && (SB_ACK || !want[s.owner])) begin
      n.busy = 1'b0;
    end
    // Arbitrated only while the bus is free, so channel 0 goes first when both want it
    if (!s.busy && |want) begin
      n.busy = 1'b1;
      n.owner = !want[0];
      n.bus.write = n.ch[!want[0]].st == CH_WRITE;
      n.bus.addr = n.bus.write ? n.ch[!want[0]].destination_pointer_register : n.ch[!want[0]].source_pointer_register;
      n.bus.wdata = n.ch[!want[0]].data;
    end
    n.bus.req = n.busy;
    n.ext_ack_n = !(n.ch[0].ext_act || n.ch[1].ext_act);
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s <= '0;
      s.ext_ack_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from flops
  assign SB_OUT = s.bus;
  assign PERIPH_ACK = s.ack;
  assign EXT_ACK_N = s.ext_ack_n;

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  logic ccr0_wr;
  assign ccr0_wr = wr && idx == {2'b00, REG_CCR};

  // Either channel may own the external pin
  sequence ext_start;
    ((s.ch[0].st == CH_WAIT && seen[0] && sel_ch[0] == SRC_EXT)
      || (s.ch[1].st == CH_WAIT && seen[1] && sel_ch[1] == SRC_EXT)) && !wr;
  endsequence
  sequence last_step0;
    s.ch[0].st == CH_ACK && s.ch[0].transfer_length_register == STEP_BYTES && !wr;
  endsequence
  sequence write_done0;
    s.busy && !s.owner && SB_ACK && !SB_ERR && s.ch[0].st == CH_WRITE && !wr;
  endsequence

  bus_priority_a: assert property (!s.busy && want[0] |=> s.busy && !s.owner)
    else $error("channel 0 not granted first");
  wait_no_bus_a: assert property (s.ch[0].st == CH_WAIT && !seen[0] && !wr |=> s.ch[0].st == CH_WAIT)
    else $error("channel left wait without request");
  ack_pulse_a: assert property (write_done0 ##0 sel_ch[0] < 4'(SRC_NUM) |=> PERIPH_ACK[sel_ch[0]] ##1 !PERIPH_ACK[sel_ch[0]])
    else $error("peripheral acknowledge not one pulse");
  count_step_a: assert property (s.ch[0].st == CH_ACK && !wr |=> s.ch[0].transfer_length_register == $past(s.ch[0].transfer_length_register) - STEP_BYTES)
    else $error("byte count not reduced by four");
  done_flag_a: assert property (last_step0 |=> s.ch[0].operation_complete_flag && CH_INT[0] && s.ch[0].st == CH_IDLE)
    else $error("completion flag or interrupt missing");
  bus_error_a: assert property (s.busy && !s.owner && SB_ACK && SB_ERR && !wr |=> s.ch[0].err && s.ch[0].channel_error_register[CER_BUS] && CH_INT[0])
    else $error("bus error not recorded");
  abort_stop_a: assert property (ccr0_wr && PWDATA[CCR_ABT] |=> s.ch[0].st == CH_IDLE && !s.ch[0].channel_enable && !(s.busy && !s.owner))
    else $error("abort did not stop channel");
  ext_ack_low_a: assert property (ext_start |=> !EXT_ACK_N)
    else $error("external acknowledge not low at first transfer");
  dir_check_a: assert property (ccr0_wr && PWDATA[CCR_CEN] && s.ch[0].st == CH_IDLE && s.ch[0].operation_definition_register[ODR_SAC] == s.ch[0].operation_definition_register[ODR_DAC] && !PWDATA[CCR_RST] |=> s.ch[0].err && s.ch[0].st == CH_IDLE)
    else $error("invalid direction accepted");

endmodule : transfer_controller

//--- testbench/bus_memory.sv
// Word memory that answers the controller's system bus requests
`timescale 1ns/1ps
module bus_memory import dma_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // System bus side
  input sb_req_t sb,
  input wire logic [3:0] delay,
  output logic ack,
  output logic err,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:63];
  logic [3:0] cnt;
  // Distinct preload so that moved words can be told apart
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 32'h5A00_0000 + i;
  end
  // Answer after the set delay; nothing exists from 0x100 up
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= 32'h0000_0000;
      cnt <= 4'h0;
    end else if (sb.req && !ack && cnt >= delay) begin
      ack <= 1'b1;
      err <= (sb.addr >= 32'h0000_0100);
      cnt <= 4'h0;
      if (sb.write && sb.addr < 32'h0000_0100) mem[sb.addr[7:2]] <= sb.wdata;
      else rdata <= mem[sb.addr[7:2]];
    end else begin
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= ~rdata; // Released data never keeps its last value
      cnt <= (sb.req && !ack) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : bus_memory

//--- testbench/test_two_channel_peripheral_dma.sv
// Self-checking bench for the two-channel peripheral transfer controller
`timescale 1ns/1ps
module test_two_channel_peripheral_dma import dma_pkg::*;;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, se, sb_ack, sb_err, ext_req, ext_ack_n;
  logic [7:0] paddr, cfg;
  logic [31:0] pwdata, prdata, sb_rdata, rd;
  logic [SRC_NUM-1:0] preq, pack;
  logic [CH_NUM-1:0] ch_int;
  logic [3:0] delay;
  sb_req_t sb;
  int n_fail, n_checks, bus_cyc;
  int ack_cnt [SRC_NUM];

  transfer_controller DUT (.REF_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SB_OUT(sb), .SB_ACK(sb_ack), .SB_ERR(sb_err), .SB_RDATA(sb_rdata),
    .PERIPH_REQ(preq), .PERIPH_ACK(pack), .EXT_REQ(ext_req), .EXT_ACK_N(ext_ack_n), .CH_INT(ch_int));
  bus_memory mem_u (.clk(clk), .rst_n(rst_n), .sb(sb), .delay(delay), .ack(sb_ack), .err(sb_err),
    .rdata(sb_rdata));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Tallies of bus occupancy and acknowledge pulses
  always @(posedge clk) begin
    if (sb.req === 1'b1) bus_cyc++;
    for (int k = 0; k < SRC_NUM; k++) if (pack[k] === 1'b1) ack_cnt[k]++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic test_done;
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic hang(input string m);
    n_fail++;
    $display("[ERR] %0t timeout %s", $time, m);
    test_done();
  endtask : hang

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang("apb");
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  function automatic logic [7:0] ra(input int ch, input logic [3:0] r);
    return 8'(ch * 64) + {2'b00, r, 2'b00};
  endfunction : ra

  task automatic prog(input int c, input logic [3:0] s, input logic [7:0] o, input logic [7:0] cc,
                      input logic [31:0] sa, input logic [31:0] da, input logic [31:0] bc);
    cfg[c*4 +: 4] = s;
    apb(1'b1, 8'h80, {24'h00_0000, cfg});
    apb(1'b1, ra(c, REG_SAR), sa);
    apb(1'b1, ra(c, REG_DAR), da);
    apb(1'b1, ra(c, REG_BCR), bc);
    apb(1'b1, ra(c, REG_ODR), {o, 24'h00_0000});
    apb(1'b1, ra(c, REG_CCR), {8'h00, cc, 16'h0000});
  endtask : prog

  task automatic wait_int(input int c);
    int i;
    for (i = 0; i < 400 && ch_int[c] !== 1'b1; i++) @(posedge clk);
    if (i == 400) hang("interrupt");
  endtask : wait_int

  // Held longer than one word, so a level-mode design would move a second word
  task automatic ext_pulse;
    ext_req <= 1'b1;
    repeat (30) @(posedge clk);
    ext_req <= 1'b0;
    @(posedge clk);
  endtask : ext_pulse

  task automatic s_reset;
    chk(ext_ack_n, 1'b1, "ext ack idle");
    chk(ch_int, 2'b00, "int idle");
    apb(1'b0, ra(0, REG_CCR), 32'h0000_0000);
    chk(rd, 32'h0000_0000, "ccr reset");
    apb(1'b0, 8'h84, 32'h0000_0000);
    chk(se, 1'b1, "unmapped");
  endtask : s_reset

  // Memory to serial port, level request, active low
  task automatic s_tx;
    int b;
    prog(0, 4'h0, 8'hA9, 8'h11, 32'h0000_0010, 32'h0000_00F0, 32'h0000_0008);
    b = bus_cyc;
    repeat (10) @(posedge clk);
    chk(bus_cyc - b, 0, "bus before request");
    preq[0] <= 1'b0;
    wait_int(0);
    preq[0] <= 1'b1;
    @(posedge clk);
    chk(mem_u.mem[60], 32'h5A00_0005, "tx word");
    chk(ack_cnt[0], 2, "ack pulses");
    apb(1'b0, ra(0, REG_CSR), 32'h0000_0000);
    chk(rd, 32'h0000_0001, "complete flag");
    apb(1'b0, ra(0, REG_SAR), 32'h0000_0000);
    chk(rd, 32'h0000_0018, "source step");
    apb(1'b0, ra(0, REG_BCR), 32'h0000_0000);
    chk(rd, 32'h0000_0000, "count done");
    apb(1'b1, ra(0, REG_CSR), 32'h0000_0000);
    chk(ch_int[0], 1'b0, "int cleared");
  endtask : s_tx

  // External pin to memory on channel 1, edge, active high, slow bus
  task automatic s_ext;
    int i;
    delay <= 4'h3;
    prog(1, SRC_EXT, 8'h68, 8'h19, 32'h0000_00F0, 32'h0000_0040, 32'h0000_0008);
    ext_pulse();
    for (i = 0; i < 40 && ext_ack_n !== 1'b0; i++) @(posedge clk);
    if (i == 40) hang("ext ack");
    chk(ext_ack_n, 1'b0, "ext ack low");
    repeat (30) @(posedge clk);
    chk(ch_int[1], 1'b0, "one word per edge");
    chk(ext_ack_n, 1'b0, "ext ack held");
    ext_pulse();
    wait_int(1);
    repeat (2) @(posedge clk);
    chk(ext_ack_n, 1'b1, "ext ack released");
    chk(mem_u.mem[17], 32'h5A00_0005, "rx word");
    apb(1'b0, ra(1, REG_DAR), 32'h0000_0000);
    chk(rd, 32'h0000_0048, "dest step");
    apb(1'b1, ra(1, REG_CSR), 32'h0000_0000);
    delay <= 4'h0;
  endtask : s_ext

  // Both channels request at once
  task automatic s_prio;
    int i;
    prog(0, 4'h1, 8'h69, 8'h11, 32'h0000_00F0, 32'h0000_0080, 32'h0000_0004);
    prog(1, 4'h3, 8'h69, 8'h11, 32'h0000_00E0, 32'h0000_00C0, 32'h0000_0004);
    preq[1] <= 1'b0;
    preq[3] <= 1'b0;
    for (i = 0; i < 40 && sb.req !== 1'b1; i++) @(posedge clk);
    if (i == 40) hang("first grant");
    chk(sb.addr, 32'h0000_00F0, "first grant");
    wait_int(0);
    wait_int(1);
    preq[1] <= 1'b1;
    preq[3] <= 1'b1;
    @(posedge clk);
    chk(mem_u.mem[48], 32'h5A00_0038, "ch1 word");
    apb(1'b1, ra(0, REG_CSR), 32'h0000_0000);
    apb(1'b1, ra(1, REG_CSR), 32'h0000_0000);
  endtask : s_prio

  // Config, alignment and bus errors with recovery
  task automatic s_err;
    logic [7:0] o [4] = '{8'hE9, 8'hA9, 8'hA9, 8'hAB};
    logic [31:0] sa [4] = '{32'h0000_0010, 32'h0000_0010, 32'h0000_0200, 32'h0000_0010};
    logic [31:0] bc [4] = '{32'h0000_0008, 32'h0000_0006, 32'h0000_0004, 32'h0000_0008};
    logic [31:0] ce [4] = '{32'h0000_0001, 32'h0000_0004, 32'h0000_0002, 32'h0000_0001};
    for (int k = 0; k < 4; k++) begin
      preq[0] <= 1'b0;
      prog(0, 4'h0, o[k], 8'h11, sa[k], 32'h0000_00F0, bc[k]);
      wait_int(0);
      preq[0] <= 1'b1;
      apb(1'b0, ra(0, REG_CER), 32'h0000_0000);
      chk(rd, ce[k], "error cause");
      apb(1'b0, ra(0, REG_CSR), 32'h0000_0000);
      chk(rd, 32'h0000_0002, "error flag");
      apb(1'b1, ra(0, REG_CCR), 32'h0080_0000);
      apb(1'b1, ra(0, REG_CSR), 32'h0000_0000);
      chk(ch_int[0], 1'b0, "recovered");
      apb(1'b0, ra(0, REG_ODR), 32'h0000_0000);
      chk(rd, 32'h0000_0000, "soft reset");
    end
  endtask : s_err

  // Abort while a bus cycle is outstanding
  task automatic s_abort;
    int i;
    delay <= 4'hC;
    prog(0, 4'h0, 8'hA9, 8'h11, 32'h0000_0010, 32'h0000_00F0, 32'h0000_0010);
    preq[0] <= 1'b0;
    for (i = 0; i < 40 && sb.req !== 1'b1; i++) @(posedge clk);
    if (i == 40) hang("abort grant");
    apb(1'b1, ra(0, REG_CCR), 32'h0040_0000);
    chk(sb.req, 1'b0, "bus dropped");
    preq[0] <= 1'b1;
    repeat (20) @(posedge clk);
    chk(ch_int[0], 1'b0, "no completion");
    apb(1'b0, ra(0, REG_BCR), 32'h0000_0000);
    chk(rd, 32'h0000_0010, "no word moved");
    delay <= 4'h0;
  endtask : s_abort

  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    preq = '1;
    ext_req = 1'b0;
    delay = 4'h0;
    cfg = 8'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    s_reset();
    s_tx();
    s_ext();
    s_prio();
    s_err();
    s_abort();
    test_done();
  end
endmodule : test_two_channel_peripheral_dma
